/* src/fsp_params.svh */
// Register indices, reset values and sizes of the fast serial port
`ifndef FSP_PARAMS_SVH
`define FSP_PARAMS_SVH
`define IDX_TO_LOW 8'hd1
`define IDX_TO_HIGH 8'hd2
`define IDX_COUNT 8'hd3
`define IDX_IRQ_EN 8'hd4
`define IDX_GUARD 8'hd5
`define IDX_RX 8'hd6
`define IDX_TX 8'hd7
`define IDX_STATUS 8'hd8
`define IDX_CONFIG 8'hd9
`define IDX_FLAGS 8'hda
`define IDX_CONTROL 8'hdb
`define IDX_ENGINE 8'hdc
`define CONFIG_RST 8'h80
`define CONTROL_RST 8'h01
`define MEM_RST_CYCLES 2'h2
`define BUF_BYTES 16
`endif

/* src/fsp_pkg.sv */
// Types of the fast serial port
package fsp_pkg;
  typedef enum logic [2:0] {
    M_IDLE = 3'b001,
    M_SHIFT = 3'b010,
    M_GUARD = 3'b100
  } master_state_t;
  typedef enum logic [1:0] {
    E_IDLE = 2'b01,
    E_RUN = 2'b10
  } engine_state_t;
  typedef struct packed {
    logic read;
    logic write;
    logic [9:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } avmm_req_t;
  typedef struct packed {
    logic [2:0] serial_clock_divider;
    logic dual_port_buffer;
    logic cpha;
    logic cpol;
    logic master;
    logic port_enable;
  } port_config_t;
  typedef struct packed {
    logic [1:0] pad;
    logic select_polarity;
    logic software_select_level;
    logic select_source;
    logic timeout_start_strobe;
    logic timeout_rearm_strobe;
    logic chip_select;
  } control_t;
  typedef struct packed {
    logic pad;
    logic rx_any_full;
    logic tx_any_empty;
    logic buffer_mem_ok;
    logic select_state;
    logic rx_all_full;
    logic tx_all_empty;
    logic port_clock_ok;
  } status_t;
  typedef struct packed {
    logic pad;
    logic [4:0] count;
    logic to_buffer;
    logic run;
  } engine_t;
endpackage

/* src/fast_serial_port.sv */
// Fast serial port: control, status, data, buffers and transfer engine
// Behaviour
// - Polarity bit picks high or low select
// - Select source picks software level or pin
// - Start strobe arms timeout, counts after first byte
// - Rearm strobe reloads the timeout counter
// - Chip-select bit drives pin in master mode unless software source
// - Reset leaves slave deselected, polarity zero
// - Status reports any and all receive buffers full
// - Status reports any and all transmit buffers empty
// - Status shows buffer memory running
// - Status shows select pin, inverted by polarity
// - Status shows port enabled and clocked
// - Transmit write loads shifter and starts sending
// - Receive read returns earliest received byte
// - Master inserts guard cycles between characters
// - Count write sets bytes per buffer
// - Count read returns bytes in completed buffer
// - Count write swaps the ping-pong buffers
// - Timeout counts divided serial clock cycles
// - Engine register hidden while port disabled
// - Buffer mode enables engine, N bytes N+1 cycles
// - Engine run stalls the processor until done
// - Config bit turns buffer memory and engine on
// - Timeout sets flag and enabled interrupt
// - Divider field selects ratio four to ninety-six
`timescale 1ns/100ps
`default_nettype none
`include "fsp_params.svh"
module fast_serial_port
  import fsp_pkg::*;
#(
  parameter int BUF_BYTES = `BUF_BYTES
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire avmm_req_t avs_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic irq_out,
  output logic cpu_stall_out,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe_out,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe_out,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe_out,
  input wire logic select_pin_in,
  output logic select_pin_out,
  output logic select_pin_oe_out,
  output logic [$clog2(BUF_BYTES)-1:0] ram_addr_out,
  output logic [7:0] ram_wdata_out,
  output logic ram_we_out,
  input wire logic [7:0] ram_rdata_in
);
  localparam int IW = $clog2(BUF_BYTES);
  localparam logic [4:0] BUF_N = 5'(BUF_BYTES);

  function automatic logic [6:0] div_ratio(input logic [2:0] s);
    case (s)
      3'h0: div_ratio = 7'd4;
      3'h1: div_ratio = 7'd5;
      3'h2: div_ratio = 7'd6;
      3'h3: div_ratio = 7'd8;
      3'h4: div_ratio = 7'd12;
      3'h5: div_ratio = 7'd24;
      3'h6: div_ratio = 7'd48;
      default: div_ratio = 7'd96;
    endcase
  endfunction

  port_config_t cfg_q;
  control_t ctrl_q;
  status_t status;
  engine_t eng_wd;
  master_state_t mst_q;
  engine_state_t e_st_q;
  logic wait_q, irq_q, en_prev_q, bm_prev_q, tx_pend_q, rx_full_q, xfer_q, act_q;
  logic to_arm_q, to_run_q, stall_q, ram_we_q, e_dir_q, byte_ev_q;
  logic sck_q, mosi_q, miso_q, sck_p_q, sel_p_q, sck_oe_q, miso_oe_q, sel_out_q, sel_oe_q;
  logic [31:0] rdata_q;
  logic [7:0] to_low_q, to_high_q, guard_q, tx_hold_q, rx_hold_q, gcnt_q, sh_q, rsh_q, byte_q;
  logic [7:0] rd_mux, wd, idx, tx_next;
  logic [1:0] ie_q, flags_q, mem_rst_q, rx_full_b_q, tx_empty_b_q;
  logic [2:0] div_sel_q;
  logic [3:0] s1_q, s2_q, bit_q;
  logic [4:0] target_q, tx_idx_q, rx_idx_q, done_cnt_q, e_n_q, e_k_q;
  logic [6:0] div_cnt_q, ratio;
  logic [15:0] to_cnt_q;
  logic [IW-1:0] ram_addr_q;
  logic [7:0] tx_buf [2][BUF_BYTES];
  logic [7:0] rx_buf [2][BUF_BYTES];
  logic req, wr, rd, en, bufmode, master, tick_full, tick_half, expire, e_done, launch;
  logic sck_s, mosi_s, miso_s, pin_s, asserted, selected, sel_slave, sel_rise;
  logic lead, trail, smp, stp, load, tx_avail, tx_take, in_bit, rx_done, to_start, to_rearm;

  assign avs_readdata_out = rdata_q;
  assign avs_waitrequest_out = wait_q;
  assign irq_out = irq_q;
  assign cpu_stall_out = stall_q;
  assign sck_out = sck_q;
  assign sck_oe_out = sck_oe_q;
  assign mosi_out = mosi_q;
  assign mosi_oe_out = sck_oe_q;
  assign miso_out = miso_q;
  assign miso_oe_out = miso_oe_q;
  assign select_pin_out = sel_out_q;
  assign select_pin_oe_out = sel_oe_q;
  assign ram_addr_out = ram_addr_q;
  assign ram_we_out = ram_we_q;

  // Bus decode: requests complete on the edge where waitrequest is low
  assign req = avs_in.read | avs_in.write;
  assign idx = avs_in.address[9:2];
  assign wd = avs_in.writedata[7:0];
  assign eng_wd = engine_t'(wd);
  assign wr = req & ~wait_q & avs_in.write & avs_in.byteenable[0];
  assign rd = req & ~wait_q & avs_in.read;
  assign en = cfg_q.port_enable;
  assign bufmode = cfg_q.dual_port_buffer & en;
  assign master = cfg_q.master;
  assign to_start = wr && idx == `IDX_CONTROL && wd[2];
  assign to_rearm = wr && idx == `IDX_CONTROL && wd[1];

  // Pin synchronisers
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s1_q <= 4'h0;
      s2_q <= 4'h0;
    end else begin
      s1_q <= {sck_in, mosi_in, miso_in, select_pin_in};
      s2_q <= s1_q;
    end
  end
  assign {sck_s, mosi_s, miso_s, pin_s} = s2_q;

  assign asserted = ctrl_q.select_source ? ctrl_q.software_select_level : pin_s;
  assign selected = asserted == ctrl_q.select_polarity;
  assign sel_slave = selected & ~master & en;
  assign sel_rise = sel_slave & ~sel_p_q;

  always_comb begin
    status = '0;
    status.rx_any_full = |rx_full_b_q;
    status.rx_all_full = &rx_full_b_q;
    status.tx_any_empty = |tx_empty_b_q;
    status.tx_all_empty = &tx_empty_b_q;
    status.buffer_mem_ok = bufmode && mem_rst_q == 2'h0;
    status.select_state = pin_s ^ ctrl_q.select_polarity;
    status.port_clock_ok = en;
  end

  always_comb begin
    rd_mux = 8'h00;
    case (idx)
      `IDX_TO_LOW: rd_mux = to_low_q;
      `IDX_TO_HIGH: rd_mux = to_high_q;
      `IDX_COUNT: rd_mux = {3'h0, done_cnt_q};
      `IDX_IRQ_EN: rd_mux = {ie_q, 6'h00};
      `IDX_GUARD: rd_mux = guard_q;
      `IDX_RX: rd_mux = rx_hold_q;
      `IDX_STATUS: rd_mux = status;
      `IDX_CONFIG: rd_mux = cfg_q;
      `IDX_FLAGS: rd_mux = {flags_q, 6'h00};
      `IDX_CONTROL: rd_mux = ctrl_q;
      `IDX_ENGINE: rd_mux = en ? {1'b0, e_n_q, e_dir_q, stall_q} : 8'h00;
      default: rd_mux = 8'h00;
    endcase
  end

  // Bus slave; new requests wait while the engine runs
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
    end else if (req && wait_q && e_st_q == E_IDLE) begin
      wait_q <= 1'b0;
      rdata_q <= {24'h0, rd_mux};
    end else begin
      wait_q <= 1'b1;
    end
  end

  // Software registers
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cfg_q <= port_config_t'(`CONFIG_RST);
      ctrl_q <= control_t'(`CONTROL_RST);
      to_low_q <= 8'h00;
      to_high_q <= 8'h00;
      guard_q <= 8'h00;
      ie_q <= 2'h0;
      div_sel_q <= 3'h0;
      en_prev_q <= 1'b0;
      bm_prev_q <= 1'b0;
      mem_rst_q <= 2'h0;
    end else begin
      if (wr && idx == `IDX_CONFIG) begin
        cfg_q <= port_config_t'(wd);
        cfg_q.master <= wd[1] & wd[0];
      end else if (!en) begin
        cfg_q.master <= 1'b0;
      end
      if (!en && wr && idx == `IDX_CONFIG) div_sel_q <= wd[7:5];
      else if (!en) div_sel_q <= cfg_q.serial_clock_divider;
      if (wr && idx == `IDX_CONTROL) begin
        ctrl_q <= control_t'({2'h0, wd[5:3], 2'h0, wd[0]});
      end
      if (wr && idx == `IDX_TO_LOW) to_low_q <= wd;
      if (wr && idx == `IDX_TO_HIGH) to_high_q <= wd;
      if (wr && idx == `IDX_GUARD) guard_q <= wd;
      if (wr && idx == `IDX_IRQ_EN) ie_q <= wd[7:6];
      en_prev_q <= en;
      bm_prev_q <= bufmode;
      if (bm_prev_q && !bufmode) mem_rst_q <= `MEM_RST_CYCLES;
      else if (mem_rst_q != 2'h0) mem_rst_q <= mem_rst_q - 2'h1;
    end
  end

  // Serial clock divider
  assign ratio = div_ratio(div_sel_q);
  assign tick_full = en && div_cnt_q == ratio - 7'd1;
  assign tick_half = en && div_cnt_q == (ratio >> 1) - 7'd1;
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) div_cnt_q <= 7'h00;
    else if (!en || tick_full) div_cnt_q <= 7'h00;
    else div_cnt_q <= div_cnt_q + 7'd1;
  end

  // Shift events for both roles
  always_comb begin
    if (master) begin
      lead = mst_q == M_SHIFT && tick_half;
      trail = mst_q == M_SHIFT && tick_full;
    end else begin
      lead = sel_slave && sck_s != cfg_q.cpol && sck_p_q == cfg_q.cpol;
      trail = sel_slave && sck_s == cfg_q.cpol && sck_p_q != cfg_q.cpol;
    end
  end
  assign smp = cfg_q.cpha ? trail : lead;
  assign stp = cfg_q.cpha ? lead : trail;
  assign in_bit = master ? miso_s : mosi_s;
  assign tx_avail = bufmode ? (xfer_q && tx_idx_q < target_q) : tx_pend_q;
  assign tx_next = bufmode ? tx_buf[act_q][tx_idx_q[IW-1:0]] : tx_hold_q;
  assign load = master ? (mst_q == M_IDLE && tx_avail && tick_full)
                       : (sel_rise || (smp && bit_q == 4'd7));
  assign tx_take = load && tx_avail;

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mst_q <= M_IDLE;
      sh_q <= 8'h00;
      rsh_q <= 8'h00;
      bit_q <= 4'h0;
      gcnt_q <= 8'h00;
      sck_q <= 1'b0;
      mosi_q <= 1'b0;
      miso_q <= 1'b0;
      byte_ev_q <= 1'b0;
      byte_q <= 8'h00;
      sck_p_q <= 1'b0;
      sel_p_q <= 1'b0;
    end else begin
      byte_ev_q <= 1'b0;
      sck_p_q <= sck_s;
      sel_p_q <= sel_slave;
      if (smp) begin
        rsh_q <= {rsh_q[6:0], in_bit};
        bit_q <= bit_q + 4'd1;
        if (bit_q == 4'd7) begin
          byte_ev_q <= 1'b1;
          byte_q <= {rsh_q[6:0], in_bit};
        end
      end
      if (stp) begin
        if (master) mosi_q <= sh_q[7];
        else miso_q <= sh_q[7];
        sh_q <= {sh_q[6:0], 1'b0};
      end
      if (!en || (!master && !sel_slave)) begin
        mst_q <= M_IDLE;
        sck_q <= cfg_q.cpol;
        bit_q <= 4'h0;
      end else begin
        if (load) begin
          bit_q <= 4'h0;
          sh_q <= cfg_q.cpha ? tx_next : {tx_next[6:0], 1'b0};
          if (!cfg_q.cpha && master) mosi_q <= tx_next[7];
          if (!cfg_q.cpha && !master) miso_q <= tx_next[7];
        end
        if (master) begin
          unique case (mst_q)
            M_IDLE: begin
              sck_q <= cfg_q.cpol;
              if (load) mst_q <= M_SHIFT;
            end
            M_SHIFT: begin
              if (tick_half || tick_full) sck_q <= ~sck_q;
              if (tick_full && (bit_q == 4'd8 || (cfg_q.cpha && bit_q == 4'd7))) begin
                mst_q <= M_GUARD;
                gcnt_q <= guard_q;
              end
            end
            M_GUARD: begin
              if (gcnt_q == 8'h00) mst_q <= M_IDLE;
              else if (tick_full) gcnt_q <= gcnt_q - 8'd1;
            end
          endcase
        end
      end
    end
  end

  // Single-byte holding registers
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tx_hold_q <= 8'h00;
      tx_pend_q <= 1'b0;
      rx_hold_q <= 8'h00;
      rx_full_q <= 1'b0;
    end else begin
      if (tx_take && !bufmode) tx_pend_q <= 1'b0;
      if (wr && idx == `IDX_TX && !bufmode) begin
        tx_hold_q <= wd;
        tx_pend_q <= 1'b1;
      end
      if (rd && idx == `IDX_RX) rx_full_q <= 1'b0;
      if (byte_ev_q && !bufmode && (!rx_full_q || (rd && idx == `IDX_RX))) begin
        rx_hold_q <= byte_q;
        rx_full_q <= 1'b1;
      end
    end
  end

  // Reception timeout on the divided clock
  assign expire = bufmode && to_run_q && tick_full && to_cnt_q == 16'h0000;
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      to_arm_q <= 1'b0;
      to_run_q <= 1'b0;
      to_cnt_q <= 16'h0000;
    end else begin
      if (to_run_q && tick_full && to_cnt_q != 16'h0000) to_cnt_q <= to_cnt_q - 16'd1;
      if (expire || !bufmode) to_run_q <= 1'b0;
      if (to_arm_q && byte_ev_q) begin
        to_arm_q <= 1'b0;
        to_run_q <= 1'b1;
      end
      if (to_rearm) to_cnt_q <= {to_high_q, to_low_q};
      if (to_start) begin
        to_arm_q <= 1'b1;
        to_run_q <= 1'b0;
        to_cnt_q <= {to_high_q, to_low_q};
      end
    end
  end

  // Ping-pong buffer management
  assign rx_done = bufmode && xfer_q && ((byte_ev_q && rx_idx_q + 5'd1 >= target_q) || expire);
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      act_q <= 1'b0;
      target_q <= 5'h00;
      tx_idx_q <= 5'h00;
      rx_idx_q <= 5'h00;
      xfer_q <= 1'b0;
      done_cnt_q <= 5'h00;
      rx_full_b_q <= 2'h0;
      tx_empty_b_q <= 2'h3;
    end else if (!bufmode) begin
      xfer_q <= 1'b0;
      rx_full_b_q <= 2'h0;
      tx_empty_b_q <= 2'h3;
    end else begin
      if (e_done && e_dir_q) tx_empty_b_q[~act_q] <= 1'b0;
      if (e_done && !e_dir_q) rx_full_b_q[~act_q] <= 1'b0;
      if (tx_take) begin
        tx_idx_q <= tx_idx_q + 5'd1;
        if (tx_idx_q + 5'd1 == target_q) tx_empty_b_q[act_q] <= 1'b1;
      end
      if (byte_ev_q && xfer_q) rx_idx_q <= rx_idx_q + 5'd1;
      if (rx_done) begin
        xfer_q <= 1'b0;
        rx_full_b_q[act_q] <= 1'b1;
        done_cnt_q <= byte_ev_q ? rx_idx_q + 5'd1 : rx_idx_q;
      end
      if (wr && idx == `IDX_COUNT) begin
        target_q <= wd[4:0];
        act_q <= ~act_q;
        tx_idx_q <= 5'h00;
        rx_idx_q <= 5'h00;
        xfer_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (bufmode && byte_ev_q && xfer_q) rx_buf[act_q][rx_idx_q[IW-1:0]] <= byte_q;
    if (e_st_q == E_RUN && e_dir_q && e_k_q != 5'h00) begin
      tx_buf[~act_q][IW'(e_k_q - 5'd1)] <= ram_rdata_in;
    end
  end

  // Interrupt flags, cleared on enable toggle
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      flags_q <= 2'h0;
      irq_q <= 1'b0;
    end else begin
      if (en != en_prev_q) begin
        flags_q <= 2'h0;
      end else begin
        if (wr && idx == `IDX_FLAGS) flags_q <= flags_q & wd[7:6];
        if (expire) flags_q[1] <= 1'b1;
        if (rx_done) flags_q[0] <= 1'b1;
      end
      irq_q <= |(flags_q & ie_q);
    end
  end

  // Buffer transfer engine
  assign launch = wr && idx == `IDX_ENGINE && en && bufmode && eng_wd.run;
  assign e_done = e_st_q == E_RUN && e_k_q == e_n_q;
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      e_st_q <= E_IDLE;
      e_n_q <= 5'h00;
      e_k_q <= 5'h00;
      e_dir_q <= 1'b0;
      stall_q <= 1'b0;
      ram_addr_q <= '0;
      ram_we_q <= 1'b0;
      ram_wdata_out <= 8'h00;
    end else begin
      unique case (e_st_q)
        E_IDLE: begin
          ram_we_q <= 1'b0;
          if (launch) begin
            e_st_q <= E_RUN;
            stall_q <= 1'b1;
            e_k_q <= 5'h00;
            e_dir_q <= eng_wd.to_buffer;
            e_n_q <= (eng_wd.count > BUF_N) ? BUF_N : eng_wd.count;
          end
        end
        E_RUN: begin
          if (e_k_q < e_n_q) begin
            ram_addr_q <= e_k_q[IW-1:0];
            ram_we_q <= ~e_dir_q;
            ram_wdata_out <= rx_buf[~act_q][e_k_q[IW-1:0]];
          end else begin
            ram_we_q <= 1'b0;
          end
          if (e_done) begin
            e_st_q <= E_IDLE;
            stall_q <= 1'b0;
          end else begin
            e_k_q <= e_k_q + 5'd1;
          end
        end
      endcase
    end
  end

  // Pin drivers
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sck_oe_q <= 1'b0;
      miso_oe_q <= 1'b0;
      sel_out_q <= 1'b1;
      sel_oe_q <= 1'b0;
    end else begin
      sck_oe_q <= master;
      miso_oe_q <= sel_slave;
      sel_out_q <= ctrl_q.chip_select;
      sel_oe_q <= master && !ctrl_q.select_source;
    end
  end
endmodule
`default_nettype wire

/* test/fsp_chk.sv */
// Checker of bus, select and transfer engine behaviour at the port pins
`timescale 1ns/100ps
`default_nettype none
`include "fsp_params.svh"
module fsp_chk
  import fsp_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire avmm_req_t avs_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic cpu_stall_out,
  input wire logic select_pin_out,
  input wire logic select_pin_oe_out,
  input wire logic ram_we_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  logic wr_w;
  logic rd_w;
  logic eng_w;
  logic [7:0] idx_w;
  logic cs_q;
  logic src_q;
  logic [1:0] age_q;
  logic [5:0] len_q;
  logic [5:0] n_q;
  assign idx_w = avs_in.address[9:2];
  assign wr_w = !avs_waitrequest_out && avs_in.write && avs_in.byteenable[0];
  assign rd_w = !avs_waitrequest_out && avs_in.read;
  assign eng_w = wr_w && idx_w == `IDX_ENGINE && avs_in.writedata[0];
  // Last written select bits and the cycles since
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cs_q <= 1'b1;
      src_q <= 1'b0;
      age_q <= 2'h3;
    end else if (wr_w && idx_w == `IDX_CONTROL) begin
      cs_q <= avs_in.writedata[0];
      src_q <= avs_in.writedata[3];
      age_q <= 2'h0;
    end else if (age_q != 2'h3) begin
      age_q <= age_q + 2'h1;
    end
  end
  // Length of the current stall and the requested byte count
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      len_q <= 6'h00;
      n_q <= 6'h00;
    end else begin
      len_q <= cpu_stall_out ? len_q + 6'h01 : 6'h00;
      if (eng_w) begin
        n_q <= (avs_in.writedata[6:2] > 5'h10) ? 6'h10 : {1'b0, avs_in.writedata[6:2]};
      end
    end
  end
  property p_cs;
    age_q == 2'h3 |-> select_pin_out == cs_q;
  endproperty
  a_cs: assert property (p_cs) else $error("select pin differs from chip-select bit");
  property p_src;
    age_q == 2'h3 && src_q |-> !select_pin_oe_out;
  endproperty
  a_src: assert property (p_src) else $error("select pin driven under software source");
  property p_len;
    $fell(cpu_stall_out) |-> len_q == n_q + 6'h01;
  endproperty
  a_len: assert property (p_len) else $error("stall length is not count plus one");
  property p_hold;
    cpu_stall_out |-> avs_waitrequest_out;
  endproperty
  a_hold: assert property (p_hold) else $error("bus answered during stall");
  property p_cause;
    $rose(cpu_stall_out) |-> $past(eng_w);
  endproperty
  a_cause: assert property (p_cause) else $error("stall without engine launch");
  property p_we;
    ram_we_out |-> cpu_stall_out;
  endproperty
  a_we: assert property (p_we) else $error("memory write outside engine run");
  property p_strobe;
    rd_w && idx_w == `IDX_CONTROL |-> avs_readdata_out[2:1] == 2'h0;
  endproperty
  a_strobe: assert property (p_strobe) else $error("timeout strobes read nonzero");
  property p_rx;
    rd_w && idx_w == `IDX_STATUS |-> !avs_readdata_out[2] || avs_readdata_out[6];
  endproperty
  a_rx: assert property (p_rx) else $error("all rx full without any rx full");
  property p_tx;
    rd_w && idx_w == `IDX_STATUS |-> !avs_readdata_out[1] || avs_readdata_out[5];
  endproperty
  a_tx: assert property (p_tx) else $error("all tx empty without any tx empty");
  c_stall: cover property ($fell(cpu_stall_out));
  c_ctl: cover property (wr_w && idx_w == `IDX_CONTROL);
  c_stat: cover property (rd_w && idx_w == `IDX_STATUS);
endmodule
bind fast_serial_port fsp_chk u_chk (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .avs_in(avs_in),
  .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
  .cpu_stall_out(cpu_stall_out), .select_pin_out(select_pin_out),
  .select_pin_oe_out(select_pin_oe_out), .ram_we_out(ram_we_out));
`default_nettype wire

/* test/fsp_peer.sv */
// Serial slave on the far side: mode zero, most significant bit first
`timescale 1ns/100ps
`default_nettype none
module fsp_peer (
  input wire logic sck_in,
  input wire logic mosi_in,
  input wire logic select_n_in,
  input wire logic [7:0] reply_in,
  output logic miso_out,
  output logic [7:0] got_out,
  output int done_out
);
  logic [7:0] shift_q = 8'h00;
  int bits_q = 0;
  initial begin
    miso_out = 1'b0;
    got_out = 8'h00;
    done_out = 0;
  end
  // First bit stands before the first sampling edge
  always @(negedge select_n_in) begin
    shift_q = reply_in;
    bits_q = 0;
    miso_out = reply_in[7];
  end
  // Released line shows the inverse of its last level
  always @(posedge select_n_in) miso_out = ~miso_out;
  always @(posedge sck_in) begin
    if (!select_n_in) begin
      got_out = {got_out[6:0], mosi_in};
      shift_q = {shift_q[6:0], 1'b0};
      bits_q++;
      if (bits_q == 8) begin
        done_out++;
        bits_q = 0;
      end
    end
  end
  always @(negedge sck_in) begin
    if (!select_n_in) miso_out = shift_q[7];
  end
endmodule
`default_nettype wire

/* test/fast_serial_port_ctrl_status_bench.sv */
// Bench of the fast serial port with a serial slave on its pins
`timescale 1ns/100ps
`default_nettype none
`include "fsp_params.svh"
`define CHECK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin n_mismatch++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, gt); end end
module fast_serial_port_ctrl_status_bench
  import fsp_pkg::*;
;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  avmm_req_t avs_q = '0;
  logic [31:0] readdata_w;
  logic wait_w, stall_w, sck_w, sck_oe_w, mosi_w, mosi_oe_w, miso_w, miso_oe_w;
  logic sel_w, sel_oe_w, we_w, sel_pin, sck_pin, peer_miso, irq_w;
  logic [3:0] raddr_w;
  logic [7:0] reply_q = 8'h00;
  logic [7:0] got_w;
  logic [7:0] q[$];
  int done_w;
  int n_mismatch = 0;
  int checks_done = 0;
  int seed = 32'hdb441e28;
  always #20 clk_in = ~clk_in;
  assign sel_pin = sel_oe_w ? sel_w : 1'b1;
  assign sck_pin = sck_oe_w ? sck_w : 1'b0;
  fast_serial_port u_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .avs_in(avs_q),
    .avs_readdata_out(readdata_w), .avs_waitrequest_out(wait_w), .irq_out(irq_w),
    .cpu_stall_out(stall_w), .sck_in(sck_pin), .sck_out(sck_w), .sck_oe_out(sck_oe_w),
    .mosi_in(mosi_oe_w ? mosi_w : ~mosi_w), .mosi_out(mosi_w), .mosi_oe_out(mosi_oe_w),
    .miso_in(miso_oe_w ? miso_w : peer_miso), .miso_out(miso_w), .miso_oe_out(miso_oe_w),
    .select_pin_in(sel_pin), .select_pin_out(sel_w), .select_pin_oe_out(sel_oe_w),
    .ram_addr_out(raddr_w), .ram_wdata_out(), .ram_we_out(we_w),
    .ram_rdata_in({4'h0, raddr_w} ^ 8'h5a));
  fsp_peer u_peer (.sck_in(sck_pin), .mosi_in(mosi_w), .select_n_in(sel_pin),
    .reply_in(reply_q), .miso_out(peer_miso), .got_out(got_w), .done_out(done_w));
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [7:0] dout);
    @(posedge clk_in);
    avs_q <= '{read: !wr, write: wr, address: {idx, 2'b00}, byteenable: 4'h1,
               writedata: {24'h0, wd}};
    @(posedge clk_in iff wait_w === 1'b0);
    dout = readdata_w[7:0];
    avs_q <= '0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [7:0] d;
    xfer(1'b1, idx, wd, d);
  endtask
  task automatic rd(input logic [7:0] idx, output logic [7:0] d);
    xfer(1'b0, idx, 8'h00, d);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #800000;
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    logic [7:0] d, tx, ex;
    int k, ns, nw;
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    rd(`IDX_CONTROL, d);
    `CHECK("control reset", 8'h01, d)
    wr(`IDX_ENGINE, 8'h0d);
    rd(`IDX_ENGINE, d);
    `CHECK("engine hidden", 8'h00, d)
    `CHECK("no stall", 1'b0, stall_w)
    rd(8'he0, d);
    `CHECK("unmapped", 8'h00, d)
    rd(`IDX_STATUS, d);
    `CHECK("status pin", 1'b1, d[3])
    `CHECK("status enabled", 1'b0, d[0])
    `CHECK("status memory", 1'b0, d[4])
    wr(`IDX_CONTROL, 8'h07);
    rd(`IDX_CONTROL, d);
    `CHECK("strobes clear", 8'h01, d)
    wr(`IDX_CONTROL, 8'h21);
    rd(`IDX_STATUS, d);
    `CHECK("status pin inverted", 1'b0, d[3])
    wr(`IDX_CONFIG, 8'ha3);
    wr(`IDX_CONTROL, 8'h00);
    rd(`IDX_STATUS, d);
    `CHECK("status enabled", 1'b1, d[0])
    `CHECK("select low", 1'b0, sel_pin)
    wr(`IDX_GUARD, 8'h02);
    rd(`IDX_GUARD, d);
    `CHECK("guard", 8'h02, d)
    for (int i = 0; i < 3; i++) begin
      tx = 8'($random(seed));
      d = 8'($random(seed));
      wr(`IDX_CONTROL, 8'h01);
      reply_q <= d;
      q.push_back(d);
      wr(`IDX_CONTROL, 8'h00);
      ns = done_w;
      wr(`IDX_TX, tx);
      for (k = 0; k < 3000 && done_w == ns; k++) @(posedge clk_in);
      repeat (50) @(posedge clk_in);
      `CHECK("byte count", ns + 1, done_w)
      `CHECK("sent byte", tx, got_w)
      rd(`IDX_RX, d);
      ex = q.pop_front();
      `CHECK("received byte", ex, d)
    end
    wr(`IDX_CONTROL, 8'h09);
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    `CHECK("source override", 1'b0, sel_oe_w)
    wr(`IDX_CONFIG, 8'hb3);
    repeat (4) @(posedge clk_in);
    rd(`IDX_STATUS, d);
    `CHECK("memory ready", 1'b1, d[4])
    for (int j = 2; j < 4; j++) begin
      wr(`IDX_ENGINE, {1'b0, 5'(j), 1'(j == 2), 1'b1});
      ns = 0;
      nw = 0;
      for (k = 0; k < 40; k++) begin
        @(negedge clk_in);
        ns += int'(stall_w === 1'b1);
        nw += int'(we_w === 1'b1);
      end
      `CHECK("stall cycles", j + 1, ns)
      `CHECK("ram writes", (j == 2) ? 0 : j, nw)
    end
    wr(`IDX_CONTROL, 8'h00);
    ns = done_w;
    wr(`IDX_COUNT, 8'h02);
    rd(`IDX_COUNT, d);
    `CHECK("count read", 8'h00, d)
    for (k = 0; k < 3000 && done_w != ns + 2; k++) @(posedge clk_in);
    repeat (50) @(posedge clk_in);
    `CHECK("buffer bytes sent", ns + 2, done_w)
    `CHECK("buffer byte from ram", 8'h5a ^ 8'h01, got_w)
    rd(`IDX_COUNT, d);
    `CHECK("count done", 8'h02, d)
    rd(`IDX_STATUS, d);
    `CHECK("rx any full", 1'b1, d[6])
    wr(`IDX_TO_LOW, 8'h03);
    wr(`IDX_CONTROL, 8'h04);
    wr(`IDX_COUNT, 8'h08);
    repeat (600) @(posedge clk_in);
    rd(`IDX_COUNT, d);
    `CHECK("count at timeout", 8'h01, d)
    wr(`IDX_IRQ_EN, 8'h80);
    repeat (2) @(posedge clk_in);
    `CHECK("timeout interrupt", 1'b1, irq_w)
    report_and_stop();
  end
endmodule
`default_nettype wire
